// *** src/dup_pkg.sv ***
// Shared constants and state types for the dual serial controller.
// Assumes one 40 MHz clock; all other rates come from cycle counters.
package dup_pkg;

  // ==========================================================
  // Timing
  localparam int DUP_CLK_NS       = 25;
  localparam int DUP_RST_MIN_NS   = 40;
  localparam int DUP_RST_MIN_CYC  =
    (DUP_RST_MIN_NS + DUP_CLK_NS - 1) / DUP_CLK_NS;
  localparam int DUP_DIV          = 16;   // Clock cycles per bit
  localparam int DUP_DEPTH        = 16;
  localparam int DUP_IR_NUM       = 3;    // Infrared pulse, sixteenths
  localparam int DUP_IR_DEN       = 16;
  localparam int DUP_RTS_HALT     = 14;
  localparam int DUP_HST_SETUP    = 1;
  localparam int DUP_HST_STROBE   = 4;
  localparam int DUP_HST_HOLD     = 2;

  // ==========================================================
  // Channel register indices
  localparam logic [2:0] DUP_R_DATA = 3'h0;
  localparam logic [2:0] DUP_R_IER  = 3'h1;
  localparam logic [2:0] DUP_R_ISR  = 3'h2;
  localparam logic [2:0] DUP_R_LCR  = 3'h3;
  localparam logic [2:0] DUP_R_MCR  = 3'h4;
  localparam logic [2:0] DUP_R_LSR  = 3'h5;
  localparam logic [2:0] DUP_R_MSR  = 3'h6;
  localparam logic [2:0] DUP_R_SPR  = 3'h7;
  localparam logic [7:0] DUP_EFR_KEY  = 8'hBF;
  localparam logic [7:0] DUP_ISR_NONE = 8'hC1;
  localparam logic [7:0] DUP_ISR_TX   = 8'hC2;
  localparam logic [7:0] DUP_ISR_RX   = 8'hC4;
  localparam logic [7:0] DUP_REG_RST  = 8'h00;

  // ==========================================================
  // Field positions
  localparam int DUP_MCR_DTR  = 0;
  localparam int DUP_MCR_RTS  = 1;
  localparam int DUP_MCR_OP2  = 3;
  localparam int DUP_MCR_IRINV = 5;
  localparam int DUP_MCR_IR   = 6;
  localparam int DUP_IER_RX   = 0;
  localparam int DUP_IER_TX   = 1;
  localparam int DUP_EFR_ARTS = 6;
  localparam int DUP_EFR_ACTS = 7;

  // ==========================================================
  // Host controller registers on AHB-Lite
  localparam logic [7:0] DUP_H_CTRL = 8'h00;
  localparam logic [7:0] DUP_H_CMD  = 8'h04;
  localparam logic [7:0] DUP_H_STAT = 8'h08;

  typedef enum logic [1:0] {
    HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD
  } dup_hst_e;

  typedef struct packed {
    logic [3:0]      pin_q;
    logic [1:0][7:0] irq_enable_reg;
    logic [1:0][7:0] lcr;
    logic [1:0][7:0] modem_control_reg;
    logic [1:0][7:0] spr;
    logic [1:0][7:0] enhanced_feature_reg;
    logic [7:0]      dout;
    logic            doe_n;
    logic            ia_o;
    logic            ia_oe_n;
    logic            ib_o;
    logic            ib_oe_n;
    logic [1:0]      aux_n;
    logic [1:0]      txr_n;
    logic [1:0]      rxr_n;
    logic [1:0]      rts_n;
    logic [1:0]      dtr_n;
  } dup_dev_s;

  localparam dup_dev_s DUP_DEV_RST = '{
    pin_q: 4'hF, irq_enable_reg: '0, lcr: '0, modem_control_reg: '0, spr: '0, enhanced_feature_reg: '0,
    dout: 8'h00, doe_n: 1'b1, ia_o: 1'b0, ia_oe_n: 1'b1,
    ib_o: 1'b0, ib_oe_n: 1'b1, aux_n: 2'h3, txr_n: 2'h0,
    rxr_n: 2'h3, rts_n: 2'h3, dtr_n: 2'h3};

endpackage : dup_pkg

// *** src/dup_bus_if.sv ***
// Host parallel bus between the controller and the host end.
// Resolves the shared data and interrupt wires from the enables.
`timescale 1ns/10ps
interface dup_bus_if;
  logic       style;
  logic       rst_pin;
  logic [2:0] addr;
  logic       rd_n;
  logic       wr_n;
  logic       cs_a_n;
  logic       cs_b_n;
  logic [7:0] hd_o;
  logic       hd_oe_n;
  logic [7:0] dd_o;
  logic       dd_oe_n;
  logic [7:0] data;
  logic       irq_a_o;
  logic       irq_a_oe_n;
  logic       irq_b_o;
  logic       irq_b_oe_n;
  logic       irq_a;
  logic       irq_b;
  logic       aux_a_n;
  logic       aux_b_n;
  logic       txr_a_n;
  logic       rxr_a_n;
  logic       txr_b_n;
  logic       rxr_b_n;

  // ==========================================================
  // Wire resolution; undriven lines float up to the pull level
  assign data  = !dd_oe_n ? dd_o : (!hd_oe_n ? hd_o : 8'hFF);
  assign irq_a = irq_a_oe_n ? 1'b1 : irq_a_o;
  assign irq_b = irq_b_oe_n ? 1'b1 : irq_b_o;

  modport dev (
    input  style, rst_pin, addr, rd_n, wr_n, cs_a_n, cs_b_n, data,
    output dd_o, dd_oe_n, irq_a_o, irq_a_oe_n, irq_b_o, irq_b_oe_n,
    output aux_a_n, aux_b_n, txr_a_n, rxr_a_n, txr_b_n, rxr_b_n
  );
  modport host (
    output style, rst_pin, addr, rd_n, wr_n, cs_a_n, cs_b_n,
    output hd_o, hd_oe_n,
    input  data, irq_a, irq_b, aux_a_n, aux_b_n,
    input  txr_a_n, rxr_a_n, txr_b_n, rxr_b_n
  );
endinterface : dup_bus_if

// *** src/dup_chan.sv ***
// One serial channel: 16-byte transmit and receive buffers, 8N1 framing,
// optional infrared pulse coding. Assumes one clock, synchronous inputs.
`timescale 1ns/10ps
module dup_chan
  import dup_pkg::*;
#(
  parameter int DIV   = dup_pkg::DUP_DIV,
  parameter int DEPTH = dup_pkg::DUP_DEPTH
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       srst,
  input  wire logic       tx_push,
  input  wire logic [7:0] tx_data,
  input  wire logic       rx_pop,
  input  wire logic       ir_mode,
  input  wire logic       rx_inv,
  input  wire logic       cts_ok,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic [7:0]      rx_data,
  output logic [$clog2(DEPTH):0] tx_cnt,
  output logic [$clog2(DEPTH):0] rx_cnt,
  output logic            tx_idle
);
  localparam int AW  = $clog2(DEPTH);
  localparam int IRW = DIV * DUP_IR_NUM / DUP_IR_DEN;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] txm;
    logic [DEPTH-1:0][7:0] rxm;
    logic [AW-1:0] twp, trp, rwp, rrp;
    logic [AW:0]   tcnt, rcnt;
    logic [9:0]    tsh;
    logic [3:0]    tbits;
    logic [15:0]   tdiv;
    logic          sout;
    logic          rbusy;
    logic [3:0]    rbits;
    logic [15:0]   rdiv;
    logic [7:0]    rsh;
    logic [15:0]   irc;
  } dup_chan_s;

  localparam dup_chan_s RST = '{sout: 1'b1, default: '0};

  dup_chan_s s, n;
  logic      line, rin, pop_tx, push_rx;

  always_comb begin
    n       = s;
    pop_tx  = 1'b0;
    push_rx = 1'b0;
    // ========================================================
    // Transmit buffer and shifter
    if (tx_push && s.tcnt != (AW+1)'(DEPTH)) begin
      n.txm[s.twp] = tx_data;
      n.twp        = s.twp + 1'b1;
    end
    if (s.tbits == 4'h0 && s.tcnt != '0 && cts_ok) begin
      pop_tx  = 1'b1;
      n.tsh   = {1'b1, s.txm[s.trp], 1'b0};
      n.trp   = s.trp + 1'b1;
      n.tbits = 4'hA;
      n.tdiv  = 16'(DIV - 1);
    end else if (s.tbits != 4'h0) begin
      if (s.tdiv == 16'h0) begin
        n.tsh   = {1'b1, s.tsh[9:1]};
        n.tbits = s.tbits - 1'b1;
        n.tdiv  = 16'(DIV - 1);
      end else begin
        n.tdiv = s.tdiv - 1'b1;
      end
    end
    n.tcnt = s.tcnt + (AW+1)'(tx_push && s.tcnt != (AW+1)'(DEPTH))
           - (AW+1)'(pop_tx);
    line = (n.tbits != 4'h0) ? n.tsh[0] : 1'b1;
    // Infrared: short high pulse for each zero bit, rests low
    if (ir_mode) begin
      n.sout = !line && (n.tdiv >= 16'(DIV - 1 - IRW));
    end else begin
      n.sout = line;
    end
    // ========================================================
    // Receive decoder and deserialiser
    if (ir_mode && (serial_in ^ rx_inv)) begin
      n.irc = 16'(DIV - 1);
    end else if (s.irc != 16'h0) begin
      n.irc = s.irc - 1'b1;
    end
    rin = ir_mode ? (s.irc == 16'h0) : serial_in;
    if (!s.rbusy) begin
      if (!rin) begin
        n.rbusy = 1'b1;
        n.rbits = 4'h0;
        n.rdiv  = 16'(DIV / 2);
      end
    end else if (s.rdiv != 16'h0) begin
      n.rdiv = s.rdiv - 1'b1;
    end else begin
      n.rdiv  = 16'(DIV - 1);
      n.rbits = s.rbits + 1'b1;
      if (s.rbits == 4'h0 && rin) begin
        n.rbusy = 1'b0;
      end else if (s.rbits == 4'h9) begin
        n.rbusy = 1'b0;
        push_rx = rin && s.rcnt != (AW+1)'(DEPTH); // Overrun drops byte
      end else if (s.rbits != 4'h0) begin
        n.rsh = {rin, s.rsh[7:1]};
      end
    end
    if (push_rx) begin
      n.rxm[s.rwp] = s.rsh;
      n.rwp        = s.rwp + 1'b1;
    end
    if (rx_pop && s.rcnt != '0) begin
      n.rrp = s.rrp + 1'b1;
    end
    n.rcnt = s.rcnt + (AW+1)'(push_rx)
           - (AW+1)'(rx_pop && s.rcnt != '0);
    if (srst) begin
      n = RST;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= RST;
    end else begin
      s <= n;
    end
  end

  assign serial_out = s.sout;
  assign rx_data    = s.rxm[s.rrp];
  assign tx_cnt     = s.tcnt;
  assign rx_cnt     = s.rcnt;
  assign tx_idle    = s.tbits == 4'h0;

endmodule : dup_chan

// *** src/dup_dev.sv ***
// Dual serial controller: host parallel bus, register sets, pins.
// Assumes host pins are synchronous to hclk and held around strobes.
`timescale 1ns/10ps
module dup_dev
  import dup_pkg::*;
#(
  parameter int DIV   = dup_pkg::DUP_DIV,
  parameter int DEPTH = dup_pkg::DUP_DEPTH
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  dup_bus_if.dev    bus,
  input  wire logic serial_in_a,
  output logic      serial_out_a,
  output logic      request_send_a_n,
  input  wire logic clear_send_a_n,
  output logic      terminal_ready_a_n,
  input  wire logic set_ready_a_n,
  input  wire logic carrier_detect_a_n,
  input  wire logic ring_indicate_a_n,
  input  wire logic serial_in_b,
  output logic      serial_out_b,
  output logic      request_send_b_n,
  input  wire logic clear_send_b_n,
  output logic      terminal_ready_b_n,
  input  wire logic set_ready_b_n,
  input  wire logic carrier_detect_b_n,
  input  wire logic ring_indicate_b_n
);
  localparam int AW = $clog2(DEPTH);

  dup_dev_s   s, n;
  logic [3:0] pin;
  logic       rst_act, sel, ch, rd_lvl, rd_go, wr_go, efr_sel;
  logic [7:0] rv;
  logic [1:0] tx_push, rx_pop, irq, tx_idle, cts_ok;
  logic [1:0] sin, sout, cts_n, dsr_n, cd_n, ri_n;
  logic [1:0][7:0]  rx_data;
  logic [1:0][AW:0] tx_cnt, rx_cnt;

  assign sin   = {serial_in_b, serial_in_a};
  assign cts_n = {clear_send_b_n, clear_send_a_n};
  assign dsr_n = {set_ready_b_n, set_ready_a_n};
  assign cd_n  = {carrier_detect_b_n, carrier_detect_a_n};
  assign ri_n  = {ring_indicate_b_n, ring_indicate_a_n};

  // ==========================================================
  // Serial engines
  for (genvar c = 0; c < 2; c++) begin : g_chan
    // Auto flow gate; with auto mode off the input is only read
    assign cts_ok[c] = !s.enhanced_feature_reg[c][DUP_EFR_ACTS] || !cts_n[c];
    dup_chan #(
      .DIV   (DIV),
      .DEPTH (DEPTH)
    ) u_chan (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .srst      (rst_act),
      .tx_push   (tx_push[c]),
      .tx_data   (bus.data),
      .rx_pop    (rx_pop[c]),
      .ir_mode   (s.modem_control_reg[c][DUP_MCR_IR]),
      .rx_inv    (s.modem_control_reg[c][DUP_MCR_IRINV]),
      .cts_ok    (cts_ok[c]),
      .serial_in (sin[c]),
      .serial_out(sout[c]),
      .rx_data   (rx_data[c]),
      .tx_cnt    (tx_cnt[c]),
      .rx_cnt    (rx_cnt[c]),
      .tx_idle   (tx_idle[c])
    );
  end

  // ==========================================================
  // Bus decode, register file, pin outputs
  always_comb begin
    n        = s;
    pin      = {bus.rd_n, bus.wr_n, bus.cs_a_n, bus.cs_b_n};
    n.pin_q  = pin;
    rst_act  = bus.style ? bus.rst_pin : !bus.rst_pin;
    tx_push  = 2'b00;
    rx_pop   = 2'b00;
    if (bus.style) begin
      sel    = !bus.cs_a_n || !bus.cs_b_n;
      ch     = bus.cs_a_n;     // A wins if both selects are low
      rd_lvl = sel && !bus.rd_n;
      rd_go  = rd_lvl && s.pin_q[3];
      wr_go  = sel && bus.wr_n && !s.pin_q[2];
    end else begin
      sel    = !bus.cs_a_n;
      ch     = bus.cs_b_n;
      rd_lvl = sel && bus.wr_n;
      rd_go  = rd_lvl && (s.pin_q[1] || !s.pin_q[2]);
      // Write commits as select rises; address must still stand
      wr_go  = bus.cs_a_n && !s.pin_q[1] && !s.pin_q[2];
    end
    for (int c = 0; c < 2; c++) begin
      irq[c] = (s.irq_enable_reg[c][DUP_IER_RX] && rx_cnt[c] != '0)
            || (s.irq_enable_reg[c][DUP_IER_TX] && tx_cnt[c] == '0);
    end
    efr_sel = s.lcr[ch] == DUP_EFR_KEY;
    case (bus.addr)
      DUP_R_DATA: rv = rx_data[ch];
      DUP_R_IER:  rv = s.irq_enable_reg[ch];
      DUP_R_ISR: begin
        if (efr_sel) begin
          rv = s.enhanced_feature_reg[ch];
        end else if (s.irq_enable_reg[ch][DUP_IER_RX] && rx_cnt[ch] != '0) begin
          rv = DUP_ISR_RX;
        end else if (s.irq_enable_reg[ch][DUP_IER_TX] && tx_cnt[ch] == '0) begin
          rv = DUP_ISR_TX;
        end else begin
          rv = DUP_ISR_NONE;
        end
      end
      DUP_R_LCR:  rv = s.lcr[ch];
      DUP_R_MCR:  rv = s.modem_control_reg[ch];
      DUP_R_LSR:  rv = {1'b0, tx_cnt[ch] == '0 && tx_idle[ch],
                        tx_cnt[ch] == '0, 4'h0, rx_cnt[ch] != '0};
      DUP_R_MSR:  rv = {!cd_n[ch], !ri_n[ch], !dsr_n[ch],
                        !cts_n[ch], 4'h0};
      DUP_R_SPR:  rv = s.spr[ch];
      default:    rv = 8'h00;
    endcase
    // Value is frozen at the strobe edge; popping moves the head
    if (rd_go) begin
      n.dout = rv;
      rx_pop[ch] = bus.addr == DUP_R_DATA && !efr_sel;
    end
    n.doe_n = !rd_lvl;
    if (wr_go) begin
      case (bus.addr)
        DUP_R_DATA: tx_push[ch] = !efr_sel;
        DUP_R_IER:  n.irq_enable_reg[ch] = bus.data;
        DUP_R_ISR: begin
          if (efr_sel) begin
            n.enhanced_feature_reg[ch] = bus.data;
          end
        end
        DUP_R_LCR:  n.lcr[ch] = bus.data;
        DUP_R_MCR:  n.modem_control_reg[ch] = bus.data;
        DUP_R_SPR:  n.spr[ch] = bus.data;
        default: ;                          // Status is read-only
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      n.aux_n[c] = !s.modem_control_reg[c][DUP_MCR_OP2];
      n.txr_n[c] = tx_cnt[c] == (AW+1)'(DEPTH);
      n.rxr_n[c] = rx_cnt[c] == '0;
      // Auto mode only withdraws a request software already made
      n.rts_n[c] = !(s.modem_control_reg[c][DUP_MCR_RTS]
                   && !(s.enhanced_feature_reg[c][DUP_EFR_ARTS]
                        && rx_cnt[c] >= (AW+1)'(DUP_RTS_HALT)));
      n.dtr_n[c] = !s.modem_control_reg[c][DUP_MCR_DTR];
    end
    if (bus.style) begin
      n.ia_o    = irq[0];
      n.ia_oe_n = !s.modem_control_reg[0][DUP_MCR_OP2];
    end else begin
      n.ia_o    = 1'b0;
      n.ia_oe_n = !(irq[0] || irq[1]);
    end
    n.ib_o    = irq[1];
    n.ib_oe_n = !s.modem_control_reg[1][DUP_MCR_OP2];
    if (rst_act) begin
      n       = DUP_DEV_RST;
      n.pin_q = pin;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= DUP_DEV_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign bus.dd_o         = s.dout;
  assign bus.dd_oe_n      = s.doe_n;
  assign bus.irq_a_o      = s.ia_o;
  assign bus.irq_a_oe_n   = s.ia_oe_n;
  assign bus.irq_b_o      = s.ib_o;
  assign bus.irq_b_oe_n   = s.ib_oe_n;
  assign bus.aux_a_n      = s.aux_n[0];
  assign bus.aux_b_n      = s.aux_n[1];
  assign bus.txr_a_n      = s.txr_n[0];
  assign bus.txr_b_n      = s.txr_n[1];
  assign bus.rxr_a_n      = s.rxr_n[0];
  assign bus.rxr_b_n      = s.rxr_n[1];
  assign serial_out_a       = sout[0];
  assign serial_out_b       = sout[1];
  assign request_send_a_n   = s.rts_n[0];
  assign request_send_b_n   = s.rts_n[1];
  assign terminal_ready_a_n = s.dtr_n[0];
  assign terminal_ready_b_n = s.dtr_n[1];

endmodule : dup_dev

// *** src/dup_host.sv ***
// Host end: turns AHB-Lite register commands into parallel bus cycles.
// Assumes a single AHB-Lite master, word accesses, zero wait states.
`timescale 1ns/10ps
module dup_host
  import dup_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  dup_bus_if.host          bus
);
  typedef struct packed {
    logic        wpend;
    logic [7:0]  wofs;
    logic [31:0] rdat;
    logic        rdy;
    dup_hst_e    st;
    logic [3:0]  tcnt;
    logic [3:0]  rcnt;
    logic        style;
    logic [2:0]  a;
    logic        ch, wr;
    logic [7:0]  wd, rd;
    logic        rst_pin, rd_n, wr_n, cs_a_n, cs_b_n, hd_oe_n;
  } dup_host_s;

  localparam dup_host_s RST = '{rdy: 1'b1, st: HS_IDLE, style: 1'b1,
    rd_n: 1'b1, wr_n: 1'b1, cs_a_n: 1'b1, cs_b_n: 1'b1,
    hd_oe_n: 1'b1, default: '0};

  dup_host_s s, n;
  logic      busy, stb;

  always_comb begin
    n     = s;
    busy  = s.st != HS_IDLE || s.rcnt != 4'h0;
    // ========================================================
    // AHB-Lite slave
    n.wpend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.wpend = hwrite && hsize == 3'h2;
      n.wofs  = haddr[7:0];
      case (haddr[7:0])
        DUP_H_CTRL: n.rdat = {31'h0, s.style};
        DUP_H_STAT: n.rdat = {14'h0, bus.irq_b, bus.irq_a, s.rd,
                              7'h0, busy};
        default:    n.rdat = 32'h0;
      endcase
    end
    if (s.rcnt != 4'h0) begin
      n.rcnt = s.rcnt - 1'b1;
    end
    if (s.wpend && s.wofs == DUP_H_CTRL) begin
      n.style = hwdata[0];
      if (hwdata[1]) begin
        n.rcnt = 4'(DUP_RST_MIN_CYC);
      end
    end
    // ========================================================
    // Parallel bus sequencer
    case (s.st)
      HS_IDLE: begin
        if (s.wpend && s.wofs == DUP_H_CMD && !busy) begin
          n.a    = hwdata[2:0];
          n.ch   = hwdata[3];
          n.wr   = hwdata[4];
          n.wd   = hwdata[15:8];
          n.st   = HS_SETUP;
          n.tcnt = 4'(DUP_HST_SETUP - 1);
        end
      end
      HS_SETUP: begin
        n.tcnt = s.tcnt - 1'b1;
        if (s.tcnt == 4'h0) begin
          n.st   = HS_STROBE;
          n.tcnt = 4'(DUP_HST_STROBE - 1);
        end
      end
      HS_STROBE: begin
        n.tcnt = s.tcnt - 1'b1;
        if (s.tcnt == 4'h0) begin
          n.rd   = s.wr ? s.rd : bus.data;
          n.st   = HS_HOLD;
          n.tcnt = 4'(DUP_HST_HOLD - 1);
        end
      end
      HS_HOLD: begin
        n.tcnt = s.tcnt - 1'b1;
        if (s.tcnt == 4'h0) begin
          n.st = HS_IDLE;
        end
      end
      default: n.st = HS_IDLE;
    endcase
    // Pins follow the next state so they change right after an edge
    stb       = n.st == HS_STROBE;
    n.rst_pin = n.style ? n.rcnt != 4'h0 : n.rcnt == 4'h0;
    n.hd_oe_n = !(n.st != HS_IDLE && n.wr);
    if (n.style) begin
      n.rd_n   = !(stb && !n.wr);
      n.wr_n   = !(stb && n.wr);
      n.cs_a_n = !(n.st != HS_IDLE && !n.ch);
      n.cs_b_n = !(n.st != HS_IDLE && n.ch);
    end else begin
      n.rd_n   = 1'b1;
      n.wr_n   = n.st == HS_IDLE || !n.wr;
      n.cs_a_n = !stb;
      n.cs_b_n = n.ch;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= RST;
    end else begin
      s <= n;
    end
  end

  assign hreadyout   = s.rdy;
  assign hrdata      = s.rdat;
  assign hresp       = 1'b0;
  assign bus.style   = s.style;
  assign bus.rst_pin = s.rst_pin;
  assign bus.addr    = s.a;
  assign bus.rd_n    = s.rd_n;
  assign bus.wr_n    = s.wr_n;
  assign bus.cs_a_n  = s.cs_a_n;
  assign bus.cs_b_n  = s.cs_b_n;
  assign bus.hd_o    = s.wd;
  assign bus.hd_oe_n = s.hd_oe_n;

endmodule : dup_host

// *** sim/dup_properties.sv ***
// Assertions on the host parallel bus pins.
// Assumes one clock; instantiated beside the bus interface.
`timescale 1ns/10ps
module dup_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic style,
  input wire logic rst_pin,
  input wire logic rd_n,
  input wire logic cs_a_n,
  input wire logic cs_b_n,
  input wire logic dd_oe_n,
  input wire logic irq_a_o,
  input wire logic irq_a_oe_n,
  input wire logic irq_b_oe_n,
  input wire logic aux_a_n,
  input wire logic aux_b_n,
  input wire logic txr_a_n,
  input wire logic rxr_a_n
);
  // ======
  // Bus and interrupt pins
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_rd_drive: assert property (style && !cs_a_n && $fell(rd_n) |=>
    !dd_oe_n) else $error("read not driven");
  chk_rd_release: assert property (style && $rose(rd_n) |->
    ##[1:3] dd_oe_n) else $error("read drive kept");
  chk_unsel_float: assert property ((style && cs_a_n && cs_b_n)[*3]
    |-> dd_oe_n) else $error("driven while unselected");
  chk_no_read: assert property ((style && rd_n)[*3] |-> dd_oe_n)
    else $error("driven without read");
  chk_aux_irq_a: assert property (style[*3] |-> aux_a_n == irq_a_oe_n)
    else $error("irq a enable wrong");
  chk_aux_irq_b: assert property (aux_b_n == irq_b_oe_n)
    else $error("irq b enable wrong");
  chk_open_drain: assert property ((!style)[*3] |->
    irq_a_oe_n || !irq_a_o) else $error("irq driven high");
  chk_pin_reset: assert property (style && rst_pin |-> ##2 (dd_oe_n &&
    aux_a_n && aux_b_n && !txr_a_n && rxr_a_n)) else $error("no reset");
  cover property (style && !dd_oe_n);
  cover property (!style && !dd_oe_n);
  cover property (!aux_b_n);
endmodule : dup_properties

// *** sim/dual_uart_pin_interface_tb.sv ***
// Bench: AHB-Lite master, host end and device, channels looped.
// Assumes the design sources under src/ are compiled first.
`timescale 1ns/10ps
module dual_uart_pin_interface_tb;
  import dup_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, sa, sb, dtr_a, rts_a;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  mdm;
  logic [7:0]  q, v [2];
  logic [31:0] haddr, hwdata, hrdata, r;
  int          fail_count, n_checks, seed, cyc, k, c;
  logic [7:0]  sq [$];
  dup_bus_if dup_bus_if_i ();
  dup_host dup_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp(),
    .bus(dup_bus_if_i));
  dup_dev #(.DIV(4)) dup_dev_i (.hclk, .hresetn, .bus(dup_bus_if_i),
    .serial_in_a(sb), .serial_out_a(sa), .request_send_a_n(rts_a),
    .clear_send_a_n(mdm[0]), .terminal_ready_a_n(dtr_a),
    .set_ready_a_n(mdm[1]), .carrier_detect_a_n(mdm[2]),
    .ring_indicate_a_n(mdm[3]), .serial_in_b(sa), .serial_out_b(sb),
    .request_send_b_n(), .clear_send_b_n(mdm[0]),
    .terminal_ready_b_n(), .set_ready_b_n(mdm[1]),
    .carrier_detect_b_n(mdm[2]), .ring_indicate_b_n(mdm[3]));
  dup_properties dup_properties_i (.hclk, .hresetn,
    .style(dup_bus_if_i.style), .rst_pin(dup_bus_if_i.rst_pin),
    .rd_n(dup_bus_if_i.rd_n), .cs_a_n(dup_bus_if_i.cs_a_n),
    .cs_b_n(dup_bus_if_i.cs_b_n), .dd_oe_n(dup_bus_if_i.dd_oe_n),
    .irq_a_o(dup_bus_if_i.irq_a_o), .irq_a_oe_n(dup_bus_if_i.irq_a_oe_n),
    .irq_b_oe_n(dup_bus_if_i.irq_b_oe_n), .aux_a_n(dup_bus_if_i.aux_a_n),
    .aux_b_n(dup_bus_if_i.aux_b_n), .txr_a_n(dup_bus_if_i.txr_a_n),
    .rxr_a_n(dup_bus_if_i.rxr_a_n));
  // ======
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  // ======
  // Tasks
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: got %0h want %0h", $time, s, e);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // Poll busy on both sides: a command sent while busy is dropped
  task automatic cmd(input logic [2:0] g, input logic ch, w,
    input logic [7:0] d);
    mdm <= 4'($random(seed));
    r = 32'h1;
    while (r[0] !== 1'b0) ahb(1'b0, DUP_H_STAT, 32'h0, r);
    ahb(1'b1, DUP_H_CMD, {16'h0, d, 3'h0, w, ch, g}, r);
    r = 32'h1;
    while (r[0] !== 1'b0) ahb(1'b0, DUP_H_STAT, 32'h0, r);
    q = r[15:8];
  endtask : cmd
  task test_done;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // ======
  // Main sequence
  initial begin
    seed = 55; hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; mdm = 4'hF;
    hwrite = 1'b0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(sa, 1'b1);
    chk({dup_bus_if_i.txr_a_n, dup_bus_if_i.rxr_a_n}, 2'h1);
    for (k = 0; k < 2; k++) begin
      ahb(1'b1, DUP_H_CTRL, {31'h0, k == 0}, r);
      for (c = 0; c < 2; c++) begin
        v[c] = 8'($random(seed));
        cmd(DUP_R_SPR, c[0], 1'b1, v[c]);
      end
      for (c = 0; c < 2; c++) begin
        cmd(DUP_R_SPR, c[0], 1'b0, 8'h00);
        chk(q, v[c]);
      end
    end
    ahb(1'b1, DUP_H_CTRL, 32'h1, r);
    cmd(DUP_R_MCR, 1'b1, 1'b1, 8'h08);
    chk(dup_bus_if_i.aux_b_n, 1'b0);
    chk(r[17], 1'b0);
    cmd(DUP_R_IER, 1'b1, 1'b1, 8'h02);
    chk(r[17], 1'b1);
    cmd(DUP_R_ISR, 1'b1, 1'b0, 8'h00);
    chk(q, DUP_ISR_TX);
    cmd(DUP_R_MSR, 1'b1, 1'b0, 8'h00);
    chk(q, {~mdm[2], ~mdm[3], ~mdm[1], ~mdm[0], 4'h0});
    cmd(DUP_R_MCR, 1'b0, 1'b1, 8'h01);
    chk(dtr_a, 1'b0);
    sq.push_back(8'($random(seed)));
    cmd(DUP_R_DATA, 1'b0, 1'b1, sq[0]);
    while (dup_bus_if_i.rxr_b_n !== 1'b0) @(posedge hclk);
    cmd(DUP_R_DATA, 1'b1, 1'b0, 8'h00);
    chk(q, sq.pop_front());
    chk({dup_bus_if_i.rxr_b_n, sa}, 2'h3);
    cmd(DUP_R_MCR, 1'b0, 1'b1, 8'h03);
    chk(rts_a, 1'b0);
    cmd(DUP_R_LCR, 1'b0, 1'b1, DUP_EFR_KEY);
    cmd(DUP_R_ISR, 1'b0, 1'b1, 8'h40);
    cmd(DUP_R_ISR, 1'b0, 1'b0, 8'h00);
    chk({q, rts_a}, 9'h080);
    ahb(1'b1, DUP_H_CTRL, 32'h3, r);
    cmd(DUP_R_SPR, 1'b0, 1'b0, 8'h00);
    chk({q, dup_bus_if_i.aux_b_n, rts_a}, 10'h003);
    cmd(DUP_R_MCR, 1'b0, 1'b1, 8'h40);
    chk(sa, 1'b0);
    test_done();
  end
endmodule : dual_uart_pin_interface_tb
